/* dv/sleep_power_controller_tb.sv */
// testbench of the sleep power controller
module sleep_power_controller_tb
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] m;
    logic [5:0] ck;
    spc_wake_t nw;
    spc_wake_t w;
  } spc_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic sleep_instr, core_halt, irq_service, adc_en, ac_on;
  spc_wake_t wake;
  spc_clk_t clk_en;
  logic [3:0] pce, pae;
  logic adc_start, ac_en, bod_en, wdt_run, wdt_on;
  logic acv, acs, vref_en, adc_power_en, adc_extended;
  logic [2:0] hsize;
  logic [5:0] in_buf_en, wpn;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  spc_row_t rows [3];
  spc_core_mdl core (.hclk(hclk), .sleep_instr(sleep_instr), .wake(wake));
  spc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sleep_instr(sleep_instr),
    .core_halt(core_halt), .irq_service(irq_service), .wake(wake),
    .brownout_level_fuses(3'h0), .startup_time_fuses(2'h0),
    .clock_source_fuses(4'h0), .adc_enabled(adc_en),
    .adc_conv_start(acs), .ac_enabled(ac_on), .ac_uses_vref(acv),
    .wdt_enabled(wdt_on), .wake_pin_need(wpn), .clk_en(clk_en),
    .periph_clk_en(pce), .periph_access_en(pae), .adc_start(adc_start),
    .adc_power_en(adc_power_en), .adc_extended(adc_extended),
    .ac_en(ac_en), .bod_en(bod_en),
    .vref_en(vref_en), .wdt_run(wdt_run), .in_buf_en(in_buf_en));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one single transfer; the bus never waits, yet the loop honours hready
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_irq();
    n = 0;
    while (irq_service !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      #1 n++;
    end
    chk({31'h0, n < 2000}, 32'h1);
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, num_checks);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      finish_test();
    end
  end
  // ==========================================================
  // sequence
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata, hsize, acs} = '0;
    {hsel, adc_en, ac_on, wdt_on, acv} = 5'h1F;
    wpn = 6'h09;
    rows[0] = '{2'h0, 6'h0F, 11'h000, 11'h001};
    rows[1] = '{2'h1, 6'h07, 11'h001, 11'h400};
    rows[2] = '{2'h2, 6'h00, 11'h400, 11'h008};
    @(posedge hclk);
    #1 chk(clk_en, 32'h3F);
    chk({irq_service, adc_start, core_halt}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    // status reads run state, all clocks, reference and detector on
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(i == 4 ? 16 : i * 4), 32'h0);
      chk(rd, (i == 3) ? 32'h0000_03FC : 32'h0);
      chk(hresp, 32'h0);
    end
    foreach (rows[i]) begin
      bus(1'b1, OFS_CTRL, {29'h0, rows[i].m, 1'b1});
      core.sleep_op();
      #1 chk(core_halt, 32'h1);
      chk(clk_en, rows[i].ck);
      chk(adc_start, rows[i].m != 2'h2);
      if (rows[i].m == 2'h2) begin
        chk({bod_en, ac_en, wdt_run}, 32'h7);
        chk(in_buf_en, wpn);
      end
      core.set_wake(rows[i].nw);
      repeat (3) @(posedge hclk);
      #1 chk(core_halt, 32'h1);
      core.set_wake(rows[i].w);
      wait_irq();
      chk(clk_en, 32'h3F);
      core.set_wake('0);
    end
    // reserved mode and a cleared enable must both leave the core alone
    bus(1'b1, OFS_CTRL, 32'h7);
    core.sleep_op();
    #1 chk(core_halt, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h0);
    core.sleep_op();
    #1 chk(core_halt, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h10);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    {acv, adc_en} <= 2'b00;
    bus(1'b1, OFS_GATE, 32'h5);
    #1 chk({pce, pae}, 32'hAA);
    bus(1'b1, OFS_GATE, 32'h0);
    #1 chk(pce, 32'hF);
    bus(1'b1, OFS_DID, 32'h3);
    #1 chk(in_buf_en, 32'h3C);
    bus(1'b1, OFS_CTRL, 32'h1D);
    bus(1'b1, OFS_CTRL, 32'h15);
    repeat (2) @(posedge hclk);
    core.sleep_op();
    #1 chk({bod_en, ac_en, vref_en}, 32'h0);
    core.set_wake(11'h008);
    wait_irq();
    chk({31'h0, n > 800}, 32'h1);
    chk(bod_en, 32'h1);
    chk(vref_en, 32'h1);
    // re-enabled adc owes one long conversion until a start clears it
    @(posedge hclk);
    adc_en <= 1'b1;
    @(posedge hclk);
    #1 chk({adc_power_en, adc_extended}, 32'h3);
    @(posedge hclk);
    acs <= 1'b1;
    @(posedge hclk);
    acs <= 1'b0;
    #1 chk(adc_extended, 32'h0);
    finish_test();
  end
endmodule

/* dv/spc_core_mdl.sv */
// core model: sleep instruction pulses and wake sources
module spc_core_mdl
  import spc_pkg::*;
(
  // clock
  input wire logic hclk,
  // towards the controller
  output logic sleep_instr,
  output spc_wake_t wake
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sleep_instr = 1'b0;
    wake = '0;
  end
  // ==========================================================
  // one-cycle pulse, as a real core gives per instruction
  task automatic sleep_op();
    @(posedge hclk);
    sleep_instr <= 1'b1;
    @(posedge hclk);
    sleep_instr <= 1'b0;
  endtask
  // wake sources are levels held until cleared
  task automatic set_wake(input spc_wake_t w);
    @(posedge hclk);
    wake <= w;
  endtask
endmodule

/* rtl/spc_pkg.sv */
// shared constants, types and register map of the sleep power controller
package spc_pkg;

  // ==========================================================
  // register map (byte offsets)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GATE = 8'h04;
  localparam logic [7:0] OFS_DID = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;

  // ==========================================================
  // control register fields
  localparam int CTRL_SE_BIT = 0;
  localparam int CTRL_SM_LSB = 1;
  localparam int CTRL_DETECTOR_OFF_WRITE_ENABLE_BIT = 3;
  localparam int CTRL_DETECTOR_OFF_IN_SLEEP_BIT = 4;

  // ==========================================================
  // reset values
  localparam logic [1:0] SM_RST = 2'h0;
  localparam logic [3:0] GATE_RST = 4'h0;
  localparam logic [5:0] DID_RST = 6'h00;

  // ==========================================================
  // peripheral gate bit positions and pin count
  localparam int PG_ADC = 0;
  localparam int PG_SER = 1;
  localparam int PG_TIM0 = 2;
  localparam int PG_TIM1 = 3;
  localparam int N_PERIPH = 4;
  localparam int N_PINS = 6;

  // ==========================================================
  // fuse codes
  localparam logic [2:0] BOD_FUSE_OFF = 3'h7;
  localparam logic [3:0] CKSEL_EXT = 4'h0;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam logic [2:0] DETECTOR_OFF_IN_SLEEP_WINDOW_CYC = 3'h4;
  localparam logic [2:0] DETECTOR_OFF_IN_SLEEP_ACTIVE_DLY_CYC = 3'h3;
  localparam logic [2:0] DETECTOR_OFF_IN_SLEEP_LIFE_CYC = 3'h3;
  localparam logic [11:0] HALT_CYC = 12'h004;
  localparam int STARTUP_UNIT_NS = 320;
  localparam int RESET_DELAY_NS = 4000;
  localparam int OSC_START_NS = 1000;
  localparam logic [11:0] STARTUP_UNIT_CYC =
    12'((STARTUP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] RESET_DELAY_CYC =
    12'((RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] OSC_START_CYC =
    12'((OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SM_IDLE = 2'b00,
    SM_ADC_NR = 2'b01,
    SM_PDOWN = 2'b10,
    SM_RSVD = 2'b11
  } spc_mode_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE = 2'b10
  } spc_state_t;

  typedef struct packed {
    logic adc_done;
    logic ext_reset;
    logic wdt_reset;
    logic bor_reset;
    logic spm_ready;
    logic ext_irq_level;
    logic ext_irq_edge;
    logic pin_change;
    logic serial_start;
    logic wdt_irq;
    logic other_io;
  } spc_wake_t;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic pck;
    logic osc;
  } spc_clk_t;

endpackage

/* rtl/spc_top.sv */
// sleep mode, clock gating and low power control with an AHB-Lite slave

// What this block does
// R01 - mode 01 sleep stops cpu, flash, io clocks; adc and others keep running
// R02 - entering adc noise reduction starts an adc conversion if adc enabled
// R03 - noise reduction wakes only on adc done, resets, spm, level, pin change
// R04 - mode 10 sleep is power-down: oscillator and all generated clocks stop
// R05 - power-down wakes only on resets, serial start, level irq, pin change
// R06 - software detector off switches detector off in power-down, back on at wake
// R07 - wake after detector off uses the full reset start-up delay
// R08 - detector-off bit one turns detector off in power-down; resets zero
// R09 - detector-off bit only set by timed sequence; plain writes ignored
// R10 - gate bit set stops peripheral clock and blocks its register access
// R11 - clearing gate bit resumes peripheral in its frozen state
// R12 - gating acts in active and idle; deeper modes stop clocks anyway; mode 01 keeps the adc clock, so its gate acts there too
// R13 - software should disable a peripheral before gating its clock
// R14 - enabled adc stays on in sleep; off-on cycle forces extended conversion
// R15 - comparator off in deep sleep unless it uses internal reference
// R16 - fuse-enabled detector stays on in every sleep unless software off
// R17 - internal reference on only while detector, comparator or adc need it
// R18 - user waits reference start-up after it was switched back on
// R19 - enabled watchdog keeps running in every sleep mode
// R20 - input buffers off when io and adc clocks stop, except wake pins
// R21 - per pin input buffer disable register under software control
// R22 - mode 00 sleep is idle: only cpu and flash clocks stop
// R23 - sleep instruction sleeps only when sleep enable is one
// R24 - timed sequence: write both ones, then within four cycles bit only
// R25 - detector-off bit active three cycles after set, then clears itself
// R26 - reserved mode 11 leaves core running on a sleep instruction
// R27 - wake restarts clocks, holds core for start-up, then serves interrupt
module spc_top
  import spc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // core
  input wire logic sleep_instr,
  output logic core_halt,
  output logic irq_service,
  // wake sources
  input wire spc_wake_t wake,
  // fuses
  input wire logic [2:0] brownout_level_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_source_fuses,
  // analog and peripheral status
  input wire logic adc_enabled,
  input wire logic adc_conv_start,
  input wire logic ac_enabled,
  input wire logic ac_uses_vref,
  input wire logic wdt_enabled,
  input wire logic [N_PINS-1:0] wake_pin_need,
  // clock and power controls
  output spc_clk_t clk_en,
  output logic [N_PERIPH-1:0] periph_clk_en,
  output logic [N_PERIPH-1:0] periph_access_en,
  output logic adc_start,
  output logic adc_power_en,
  output logic adc_extended,
  output logic ac_en,
  output logic bod_en,
  output logic vref_en,
  output logic wdt_run,
  output logic [N_PINS-1:0] in_buf_en
);

  // ==========================================================
  // state
  spc_state_t state;
  spc_mode_t mode;
  logic sleep_enable;
  spc_mode_t sleep_mode_select;
  logic [N_PERIPH-1:0] peripheral_clock_gate_reg;
  logic [N_PINS-1:0] digital_input_disable_reg;
  logic detector_off_write_enable;
  logic [2:0] detector_off_write_enable_cnt;
  logic detector_off_in_sleep;
  logic [2:0] detector_off_in_sleep_age;
  logic detector_off_in_sleep_active;
  logic bod_off_latch;
  logic adc_was_on;
  logic adc_en_d;
  logic wait_done;
  logic wait_load;
  logic [11:0] wait_count;
  logic wake_ok;
  logic bod_fuse_on;
  logic sleep_go;
  logic dphase;
  logic dwrite;
  logic [7:0] daddr;

  assign bod_fuse_on = brownout_level_fuses != BOD_FUSE_OFF;
  // see R23, see R26
  assign sleep_go = state == ST_RUN && sleep_instr && sleep_enable &&
    sleep_mode_select != SM_RSVD;

  // ==========================================================
  // ahb-lite slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase <= 1'b0;
      dwrite <= 1'b0;
      daddr <= 8'h00;
    end else if (hready) begin
      dphase <= hsel && htrans[1] && hsize == 3'h2;
      dwrite <= hwrite;
      daddr <= haddr[7:0];
    end
  end

  logic wr_ctrl;
  assign wr_ctrl = dphase && dwrite && daddr == OFS_CTRL;

  // read data captured in the address phase; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        OFS_CTRL: hrdata <= {27'h0, detector_off_in_sleep,
          detector_off_write_enable, sleep_mode_select, sleep_enable};
        OFS_GATE: hrdata <= {28'h0, peripheral_clock_gate_reg};
        OFS_DID: hrdata <= {26'h0, digital_input_disable_reg};
        OFS_STAT: hrdata <= {22'h0, bod_en, vref_en, clk_en, state};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // plain control fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_enable <= 1'b0;
      sleep_mode_select <= SM_IDLE;
    end else if (wr_ctrl) begin
      sleep_enable <= hwdata[CTRL_SE_BIT];
      sleep_mode_select <= spc_mode_t'(hwdata[CTRL_SM_LSB +: 2]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peripheral_clock_gate_reg <= GATE_RST;
      digital_input_disable_reg <= DID_RST;
    end else if (dphase && dwrite) begin
      if (daddr == OFS_GATE) begin
        peripheral_clock_gate_reg <= hwdata[N_PERIPH-1:0]; // see R10, see R11
      end
      if (daddr == OFS_DID) begin
        digital_input_disable_reg <= hwdata[N_PINS-1:0]; // see R21
      end
    end
  end

  // ==========================================================
  // timed sequence for the detector-off bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      detector_off_write_enable <= 1'b0;
      detector_off_write_enable_cnt <= 3'h0;
    end else if (wr_ctrl && hwdata[CTRL_DETECTOR_OFF_IN_SLEEP_BIT] &&
                 hwdata[CTRL_DETECTOR_OFF_WRITE_ENABLE_BIT]) begin
      detector_off_write_enable <= 1'b1; // see R24
      detector_off_write_enable_cnt <= DETECTOR_OFF_IN_SLEEP_WINDOW_CYC;
    end else if (wr_ctrl && detector_off_write_enable) begin
      detector_off_write_enable <= 1'b0;
      detector_off_write_enable_cnt <= 3'h0;
    end else if (detector_off_write_enable_cnt != 3'h0) begin
      detector_off_write_enable_cnt <= detector_off_write_enable_cnt - 3'h1;
      detector_off_write_enable <= detector_off_write_enable_cnt != 3'h1;
    end
  end

  // a plain write never reaches the bit: only the second step sets it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      detector_off_in_sleep <= 1'b0; // see R08
      detector_off_in_sleep_age <= 3'h0;
    end else if (wr_ctrl && detector_off_write_enable &&
                 hwdata[CTRL_DETECTOR_OFF_IN_SLEEP_BIT] && !hwdata[CTRL_DETECTOR_OFF_WRITE_ENABLE_BIT]) begin
      detector_off_in_sleep <= 1'b1; // see R09, see R24
      detector_off_in_sleep_age <= 3'h1;
    end else if (detector_off_in_sleep) begin
      if (detector_off_in_sleep_age == DETECTOR_OFF_IN_SLEEP_ACTIVE_DLY_CYC + DETECTOR_OFF_IN_SLEEP_LIFE_CYC) begin
        detector_off_in_sleep <= 1'b0; // see R25
        detector_off_in_sleep_age <= 3'h0;
      end else begin
        detector_off_in_sleep_age <= detector_off_in_sleep_age + 3'h1;
      end
    end
  end

  assign detector_off_in_sleep_active = detector_off_in_sleep &&
    detector_off_in_sleep_age > DETECTOR_OFF_IN_SLEEP_ACTIVE_DLY_CYC; // see R25

  // ==========================================================
  // wake qualification per mode
  always_comb begin
    wake_ok = 1'b0;
    case (mode)
      SM_IDLE: wake_ok = |wake;
      SM_ADC_NR: wake_ok = wake.adc_done || wake.ext_reset || // see R03
        wake.wdt_reset || wake.bor_reset || wake.spm_ready ||
        wake.ext_irq_level || wake.pin_change;
      SM_PDOWN: wake_ok = wake.ext_reset || wake.wdt_reset || // see R05
        wake.bor_reset || wake.serial_start || wake.ext_irq_level ||
        wake.pin_change;
      default: wake_ok = 1'b0;
    endcase
  end

  // hold time: start-up from fuses, plus reset delay when the detector
  // was off, plus oscillator start after power-down unless the clock is external, plus halt cycles
  always_comb begin
    wait_count = HALT_CYC + (STARTUP_UNIT_CYC << startup_time_fuses);
    if (bod_off_latch && mode == SM_PDOWN && bod_fuse_on) begin
      wait_count = wait_count + RESET_DELAY_CYC; // see R07
    end
    if (mode == SM_PDOWN && clock_source_fuses != CKSEL_EXT) begin
      wait_count = wait_count + OSC_START_CYC;
    end
  end

  assign wait_load = state == ST_SLEEP && wake_ok;

  spc_wait u_wait (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(wait_load),
    .count(wait_count),
    .busy(),
    .done(wait_done)
  );

  // ==========================================================
  // sleep state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_RUN;
      mode <= SM_IDLE;
      bod_off_latch <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (sleep_go) begin
            state <= ST_SLEEP;
            mode <= sleep_mode_select;
            bod_off_latch <= detector_off_in_sleep_active; // see R06
          end
        end
        ST_SLEEP: begin
          if (wake_ok) begin
            state <= ST_WAKE; // see R27
          end
        end
        ST_WAKE: begin
          if (wait_done) begin
            state <= ST_RUN;
            bod_off_latch <= 1'b0;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_service <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      irq_service <= state == ST_WAKE && wait_done; // see R27
      adc_start <= sleep_go && adc_enabled && // see R02
        (sleep_mode_select == SM_ADC_NR || sleep_mode_select == SM_IDLE);
    end
  end

  assign core_halt = state != ST_RUN;

  // ==========================================================
  // clock domains per state and mode
  always_comb begin
    clk_en = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1,
               pck: 1'b1, osc: 1'b1};
    if (state == ST_SLEEP) begin
      clk_en.cpu = 1'b0;
      clk_en.flash = 1'b0; // see R22
      case (mode)
        SM_ADC_NR: clk_en.io = 1'b0; // see R01
        SM_PDOWN: begin
          clk_en = '0; // see R04
        end
        default: clk_en.io = 1'b1;
      endcase
    end else if (state == ST_WAKE) begin
      clk_en.cpu = 1'b0; // see R27
      clk_en.flash = 1'b0;
    end
  end

  // ==========================================================
  // peripheral clock gating
  genvar gi;
  generate
    for (gi = 0; gi < N_PERIPH; gi++) begin : g_periph
      logic dom_on;
      assign dom_on = (gi == PG_ADC) ? clk_en.adc : clk_en.io;
      // a stopped clock freezes state, so ungating resumes it as it was
      assign periph_clk_en[gi] = dom_on && // see R10, see R11, see R12
        !peripheral_clock_gate_reg[gi];
      assign periph_access_en[gi] = !peripheral_clock_gate_reg[gi]; // see R10
    end
  endgenerate

  // ==========================================================
  // input buffers
  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_pin
      assign in_buf_en[gi] = !digital_input_disable_reg[gi] && // see R21
        ((clk_en.io || clk_en.adc) || wake_pin_need[gi]); // see R20
    end
  endgenerate

  // ==========================================================
  // analog blocks
  logic deep_sleep;
  assign deep_sleep = state == ST_SLEEP && mode == SM_PDOWN;
  assign adc_power_en = adc_enabled; // see R14
  assign wdt_run = wdt_enabled; // see R19
  // see R15
  assign ac_en = ac_enabled && (!deep_sleep || ac_uses_vref);
  // see R06, see R08, see R16
  assign bod_en = bod_fuse_on && !(deep_sleep && bod_off_latch);
  // see R17
  assign vref_en = bod_en || (ac_en && ac_uses_vref) || adc_enabled;

  // an off-on cycle of the adc needs the long first conversion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_en_d <= 1'b0;
      adc_was_on <= 1'b0;
      adc_extended <= 1'b0;
    end else begin
      adc_en_d <= adc_enabled;
      if (adc_enabled) begin
        adc_was_on <= 1'b1;
      end
      if (adc_enabled && !adc_en_d && adc_was_on) begin
        adc_extended <= 1'b1; // see R14
      end else if (adc_conv_start) begin
        adc_extended <= 1'b0;
      end
    end
  end

  // ==========================================================
  // assertions
  property p_no_se;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_RUN && sleep_instr && !sleep_enable |=> state == ST_RUN;
  endproperty
  a_no_se: assert property (p_no_se) // see R23
    else $error("slept without sleep enable");

  property p_rsvd;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_RUN && sleep_instr && sleep_mode_select == SM_RSVD
      |=> !core_halt;
  endproperty
  a_rsvd: assert property (p_rsvd) // see R26
    else $error("reserved mode halted core");

  property p_anr_clk;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_SLEEP && mode == SM_ADC_NR
      |-> !clk_en.cpu && !clk_en.io && clk_en.adc && clk_en.osc;
  endproperty
  a_anr_clk: assert property (p_anr_clk) // see R01
    else $error("wrong clocks in noise reduction");

  property p_pd_clk;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_SLEEP && mode == SM_PDOWN |-> clk_en == '0;
  endproperty
  a_pd_clk: assert property (p_pd_clk) // see R04
    else $error("clock running in power-down");

  property p_adc_go;
    @(posedge hclk) disable iff (!hresetn)
    sleep_go && adc_enabled && sleep_mode_select == SM_ADC_NR
      |=> adc_start ##1 !adc_start;
  endproperty
  a_adc_go: assert property (p_adc_go) // see R02
    else $error("no adc start on entry");

  property p_pd_wake;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_SLEEP && mode == SM_PDOWN && !wake.pin_change &&
      !wake.ext_irq_level && !wake.serial_start && !wake.ext_reset &&
      !wake.wdt_reset && !wake.bor_reset |=> state == ST_SLEEP;
  endproperty
  a_pd_wake: assert property (p_pd_wake) // see R05
    else $error("power-down woke on illegal source");

  property p_bod_off;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_RUN && sleep_go && detector_off_in_sleep_active &&
      sleep_mode_select == SM_PDOWN |=> !bod_en;
  endproperty
  a_bod_off: assert property (p_bod_off) // see R06
    else $error("detector not off in power-down");

  property p_bod_back;
    @(posedge hclk) disable iff (!hresetn)
    state != ST_SLEEP |-> bod_en == bod_fuse_on;
  endproperty
  a_bod_back: assert property (p_bod_back) // see R16
    else $error("detector state wrong while awake");

  property p_plain_wr;
    @(posedge hclk) disable iff (!hresetn)
    wr_ctrl && !detector_off_write_enable && !detector_off_in_sleep
      |=> !detector_off_in_sleep;
  endproperty
  a_plain_wr: assert property (p_plain_wr) // see R09
    else $error("plain write set detector-off bit");

  property p_detector_off_in_sleep_life;
    @(posedge hclk) disable iff (!hresetn)
    $rose(detector_off_in_sleep) |-> !detector_off_in_sleep_active [*3] ##1
      detector_off_in_sleep_active [*3] ##1 !detector_off_in_sleep;
  endproperty
  a_detector_off_in_sleep_life: assert property (p_detector_off_in_sleep_life) // see R25
    else $error("detector-off bit timing wrong");

  property p_gate;
    @(posedge hclk) disable iff (!hresetn)
    peripheral_clock_gate_reg[PG_TIM0] |-> !periph_clk_en[PG_TIM0] &&
      !periph_access_en[PG_TIM0];
  endproperty
  a_gate: assert property (p_gate) // see R10
    else $error("gated peripheral still clocked");

  property p_buf;
    @(posedge hclk) disable iff (!hresetn)
    deep_sleep && !wake_pin_need[0] |-> !in_buf_en[0];
  endproperty
  a_buf: assert property (p_buf) // see R20
    else $error("input buffer on in power-down");

  property p_wake_hold;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_SLEEP && wake_ok |=> core_halt [*4];
  endproperty
  a_wake_hold: assert property (p_wake_hold) // see R27
    else $error("core released too early");

  c_anr: cover property (@(posedge hclk) disable iff (!hresetn)
    sleep_go && sleep_mode_select == SM_ADC_NR);
  c_pd_bod: cover property (@(posedge hclk) disable iff (!hresetn)
    deep_sleep && bod_off_latch);
  c_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    irq_service);
  c_seq: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(detector_off_in_sleep_active));

endmodule

/* rtl/spc_wait.sv */
// down counter that times the wake-up hold of the core
module spc_wait
  import spc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic load,
  input wire logic [11:0] count,
  // status
  output logic busy,
  output logic done
);

  // ==========================================================
  // counter
  logic [11:0] remain;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      remain <= 12'h000;
      busy <= 1'b0;
    end else if (load) begin
      remain <= count;
      busy <= 1'b1;
    end else if (busy) begin
      remain <= remain - 12'h001;
      if (remain <= 12'h001) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done <= 1'b0;
    end else begin
      done <= busy && !load && remain <= 12'h001;
    end
  end

endmodule
